// ### verilog/dhp_host_port.sv
// Purpose: Host side of the framer, two bus styles chosen by a strap.
// Assumes: Register storage sits outside and answers reads in the same cycle.
// Notes: Strobes are sampled by the system clock, so edges are seen late
//        by up to two clock periods; hosts must hold strobes accordingly.
//        Address and data pass the same stages, so they line up with the edges.
`timescale 1ns/1ns

// **************************************************************
// Operation
// **************************************************************
module dhp_host_port (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_bus_style_select,
    input wire logic i_cs_b,
    input wire dhp_pkg::dhp_addr_t i_addr,
    input wire dhp_pkg::dhp_data_t i_data,
    output dhp_pkg::dhp_data_t o_data,
    output logic o_data_oe,
    input wire logic i_address_latch_strobe,
    input wire logic i_read_or_data_strobe,
    input wire logic i_write_or_dir,
    output logic o_cycle_done_ack,
    output logic o_int_oe,
    output logic o_int_b,
    input wire logic i_int_pending,
    output logic o_rst_sys_b,
    output dhp_pkg::dhp_addr_t o_reg_addr,
    output dhp_pkg::dhp_data_t o_reg_wdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    input wire dhp_pkg::dhp_data_t i_reg_rdata
);
    import dhp_pkg::*;

    // **************************************************************
    // Reset and synchronisers
    // **************************************************************
    logic rst_sys_b;
    logic [3:0] pins_sync;
    logic [3:0] pins_rst;
    logic cs_b_s;
    logic als_s;
    logic rds_s;
    logic wrd_s;
    logic [DHP_ADDR_W+DHP_DATA_W-1:0] bus_sync;
    logic [DHP_ADDR_W+DHP_DATA_W-1:0] bus_rst;
    dhp_addr_t addr_s;
    dhp_data_t data_s;

    dhp_rst_sync u_rst_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .o_rst_sys_b(rst_sys_b)
    );

    // Idle levels: chip select, read and write high; latch strobe low
    assign pins_rst = DHP_PIN_IDLE;

    dhp_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_sys_b(rst_sys_b),
        .i_async({i_cs_b, i_address_latch_strobe, i_read_or_data_strobe, i_write_or_dir}
                 ^ pins_rst),
        .i_rst_val(pins_rst),
        .o_sync(pins_sync)
    );

    assign cs_b_s = pins_sync[3];
    assign als_s = pins_sync[2];
    assign rds_s = pins_sync[1];
    assign wrd_s = pins_sync[0];

    // **************************************************************
    // Address and data alignment
    // **************************************************************
    // Address and data ride the same two stages as the strobes, so the
    // value used at a detected edge is the one present at the pin edge.
    // Without this a host that moves the bus right after the edge
    // would have a later value latched.
    assign bus_rst = {DHP_ADDR_RST, DHP_DATA_RST};

    dhp_sync #(
        .WIDTH(DHP_ADDR_W + DHP_DATA_W)
    ) u_bus_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_sys_b(rst_sys_b),
        .i_async({i_addr, i_data} ^ bus_rst),
        .i_rst_val(bus_rst),
        .o_sync(bus_sync)
    );

    assign addr_s = bus_sync[DHP_DATA_W +: DHP_ADDR_W];
    assign data_s = bus_sync[DHP_DATA_W-1:0];

    // **************************************************************
    // Access state
    // **************************************************************
    typedef struct packed {
        dhp_state_e state;
        logic style;
        logic style_valid;
        // Previous synchronised levels, for edge detection
        logic als_d;
        logic rds_d;
        logic wrd_d;
        logic [3:0] ack_cnt;
        logic ack;
        logic oe;
        dhp_addr_t addr;
        dhp_data_t rdata;
        dhp_data_t wdata;
        logic wr;
        logic rd;
    } dhp_port_s;

    dhp_port_s st_ff;
    dhp_port_s nxt_st;

    // **************************************************************
    // Edge decode
    // **************************************************************
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    function automatic logic rose(input logic prev, input logic cur);
        rose = ~prev & cur;
    endfunction

    logic sel;
    logic rd_start;
    logic rd_end;
    logic wr_start;
    logic wr_end;
    logic addr_take;

    always_comb begin
        sel = ~cs_b_s;
        // strap picks which strobe edges mean what
        if (st_ff.style) begin
            addr_take = rose(st_ff.als_d, als_s);
            rd_start = fell(st_ff.rds_d, rds_s) & wrd_s;
            wr_start = fell(st_ff.rds_d, rds_s) & ~wrd_s;
            rd_end = rose(st_ff.rds_d, rds_s);
            wr_end = rose(st_ff.rds_d, rds_s);
        end else begin
            addr_take = fell(st_ff.als_d, als_s);
            rd_start = fell(st_ff.rds_d, rds_s);
            wr_start = fell(st_ff.wrd_d, wrd_s);
            rd_end = rose(st_ff.rds_d, rds_s);
            wr_end = rose(st_ff.wrd_d, wrd_s);
        end
    end

    // **************************************************************
    // Next state
    // **************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.als_d = als_s;
        nxt_st.rds_d = rds_s;
        nxt_st.wrd_d = wrd_s;
        nxt_st.wr = 1'b0;
        nxt_st.rd = 1'b0;
        // Strap is caught once after reset release, never under reset
        if (!st_ff.style_valid) begin
            nxt_st.style = i_bus_style_select;
            nxt_st.style_valid = 1'b1;
        end
        if (addr_take && sel) begin
            nxt_st.addr = addr_s;
        end
        case (st_ff.state)
            DHP_IDLE: begin
                nxt_st.ack = 1'b0;
                nxt_st.oe = 1'b0;
                // A strobe edge while deselected is dropped, not queued
                if (sel && rd_start) begin
                    nxt_st.state = DHP_READ;
                    nxt_st.rd = 1'b1;
                    nxt_st.ack_cnt = DHP_ACK_CNT_INIT;
                end else if (sel && wr_start) begin
                    nxt_st.state = DHP_WRITE;
                    nxt_st.ack_cnt = DHP_ACK_CNT_INIT;
                end
            end
            DHP_READ: begin
                nxt_st.oe = 1'b1;
                // Store answers in the pulse cycle, so the byte is taken then
                if (st_ff.rd) begin
                    nxt_st.rdata = i_reg_rdata;
                end
                if (st_ff.ack_cnt != 4'h0) begin
                    nxt_st.ack_cnt = st_ff.ack_cnt - 4'h1;
                end else begin
                    nxt_st.ack = 1'b1;
                end
                if (rd_end || cs_b_s) begin
                    nxt_st.oe = 1'b0;
                    nxt_st.state = DHP_DONE;
                end
            end
            DHP_WRITE: begin
                // Data strobe low holds write data; latch on its release
                if (st_ff.style) begin
                    nxt_st.wdata = data_s;
                end
                if (st_ff.ack_cnt != 4'h0) begin
                    nxt_st.ack_cnt = st_ff.ack_cnt - 4'h1;
                end else begin
                    nxt_st.ack = 1'b1;
                end
                if (wr_end) begin
                    if (!st_ff.style) begin
                        nxt_st.wdata = data_s;
                    end
                    nxt_st.wr = sel;
                    nxt_st.ack = 1'b1;
                    nxt_st.state = DHP_DONE;
                end else if (cs_b_s) begin
                    // Deselect mid-write abandons the byte; nothing reaches the store
                    nxt_st.state = DHP_DONE;
                end
            end
            DHP_DONE: begin
                // Ack held one cycle past the strobe release, then withdrawn
                nxt_st.ack = 1'b0;
                nxt_st.oe = 1'b0;
                nxt_st.state = DHP_IDLE;
            end
            default: begin
                nxt_st.state = DHP_IDLE;
            end
        endcase
    end

    // **************************************************************
    // Register update
    // **************************************************************
    // Fields reset one by one so each power-on default stays visible
    always_ff @(posedge i_clk_sys or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            st_ff.state <= DHP_IDLE;
            st_ff.style <= 1'b0;
            st_ff.style_valid <= 1'b0;
            st_ff.als_d <= 1'b0;
            st_ff.rds_d <= 1'b1;
            st_ff.wrd_d <= 1'b1;
            st_ff.ack_cnt <= 4'h0;
            st_ff.ack <= 1'b0;
            st_ff.oe <= 1'b0;
            st_ff.addr <= DHP_ADDR_RST;
            st_ff.rdata <= DHP_DATA_RST;
            st_ff.wdata <= DHP_DATA_RST;
            st_ff.wr <= 1'b0;
            st_ff.rd <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // **************************************************************
    // Outputs
    // **************************************************************
    assign o_data = st_ff.rdata;
    // Enable drops at once on a deselect, ahead of the state machine
    assign o_data_oe = st_ff.oe & ~st_ff.rd & ~cs_b_s;
    // Both styles present the done level low on the shared pin
    assign o_cycle_done_ack = ~st_ff.ack;
    // Open drain: drive low only, so output level is always zero
    assign o_int_b = 1'b0;
    assign o_int_oe = i_int_pending;
    assign o_rst_sys_b = rst_sys_b;
    assign o_reg_addr = st_ff.addr;
    assign o_reg_wdata = st_ff.wdata;
    assign o_reg_wr = st_ff.wr;
    assign o_reg_rd = st_ff.rd;
endmodule

// ### verilog/dhp_pkg.sv
// Purpose: Shared constants and types for the dual style host bus port.
// Assumes: One 20 MHz system clock; host pins are asynchronous and pass a two flop sync.
// Notes: Register contents live outside this block, behind a byte access port.
package dhp_pkg;
    localparam int unsigned DHP_ADDR_W = 9;
    localparam int unsigned DHP_DATA_W = 8;
    localparam int unsigned DHP_SYNC_STAGES = 2;
    // Clock rate and least ready delay after a strobe edge is seen
    localparam int unsigned DHP_CLK_MHZ = 20;
    localparam int unsigned DHP_ACK_DELAY_NS = 50;
    localparam int unsigned DHP_ACK_DELAY_CYC =
        ((DHP_ACK_DELAY_NS * DHP_CLK_MHZ + 999) / 1000 < 1) ? 1 :
        (DHP_ACK_DELAY_NS * DHP_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] DHP_ACK_CNT_INIT = 4'(DHP_ACK_DELAY_CYC);
    localparam logic [DHP_ADDR_W-1:0] DHP_ADDR_RST = 9'h000;
    localparam logic [DHP_DATA_W-1:0] DHP_DATA_RST = 8'h00;
    // Synchroniser reset levels {chip select, latch strobe, read, write}
    localparam logic [3:0] DHP_PIN_IDLE = 4'hB;

    typedef logic [DHP_ADDR_W-1:0] dhp_addr_t;
    typedef logic [DHP_DATA_W-1:0] dhp_data_t;

    typedef enum logic [2:0] {
        DHP_IDLE,
        DHP_READ,
        DHP_WRITE,
        DHP_DONE
    } dhp_state_e;
endpackage

// ### verilog/dhp_sync.sv
// Purpose: Two flip-flop synchroniser for a group of host pin levels.
// Assumes: Inputs may change at any time relative to the clock.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
module dhp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_sys_b,
    input wire logic [WIDTH-1:0] i_async,
    input wire logic [WIDTH-1:0] i_rst_val,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta_ff;
        logic [WIDTH-1:0] sync_ff;
    } dhp_sync_s;

    dhp_sync_s st_ff;
    dhp_sync_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta_ff = i_async;
        nxt_st.sync_ff = st_ff.meta_ff;
    end

    // Reset value is a parameter-like constant tied at the instance
    always_ff @(posedge i_clk_sys or negedge i_rst_sys_b) begin
        if (!i_rst_sys_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.sync_ff ^ i_rst_val;
endmodule

// ### verilog/dhp_rst_sync.sv
// Purpose: Releases the master reset through two flip-flops.
// Assumes: i_rst_b may fall at any time; assertion acts at once.
// Notes: Release is aligned to the system clock.
`timescale 1ns/1ns
module dhp_rst_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    output logic o_rst_sys_b
);
    typedef struct packed {
        logic stage1_ff;
        logic stage2_ff;
    } dhp_rst_s;

    dhp_rst_s st_ff;
    dhp_rst_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1_ff = 1'b1;
        nxt_st.stage2_ff = st_ff.stage1_ff;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rst_sys_b = st_ff.stage2_ff;
endmodule

// ### verif/dhp_host_port_asserts.sv
// Purpose: Concurrent checks on the host port pins.
// Assumes: Pins pass a two flop sync before use.
// Notes: Bound into dhp_host_port below.
`timescale 1ns/1ns
module dhp_host_port_asserts
import dhp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire dhp_data_t o_data,
    input wire logic o_data_oe,
    input wire logic o_cycle_done_ack,
    input wire logic o_int_oe,
    input wire logic o_int_b,
    input wire logic i_int_pending,
    input wire logic o_rst_sys_b,
    input wire logic o_reg_wr,
    input wire logic o_reg_rd,
    input wire dhp_data_t i_reg_rdata
);
    // ****
    // Checks
    // ****
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    // Byte taken by the last read pulse
    dhp_data_t rd_cap_ff;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_cap_ff <= DHP_DATA_RST;
        end else if (o_reg_rd) begin
            rd_cap_ff <= i_reg_rdata;
        end
    end
    sequence s_rd_req;
        o_reg_rd;
    endsequence
    sequence s_drive;
        ##[1:3] (o_data_oe && o_data == rd_cap_ff);
    endsequence
    a_int_follow: assert property (o_int_oe == i_int_pending && !o_int_b)
        else $error("interrupt pin not following pending");
    a_rd_drive: assert property (s_rd_req |-> s_drive)
        else $error("read data not driven");
    a_data_source: assert property (o_data_oe |-> o_data == rd_cap_ff)
        else $error("driven byte differs from register");
    a_wr_quiet: assert property (o_reg_wr |-> !o_data_oe && !o_reg_rd)
        else $error("bus driven during write");
    a_cs_no_write: assert property (i_cs_b [*4] |-> !o_reg_wr && !o_reg_rd)
        else $error("access while deselected");
    a_cs_no_drive: assert property (i_cs_b [*5] |-> !o_data_oe)
        else $error("bus driven while deselected");
    a_cs_gates: assert property ((o_reg_wr || o_reg_rd) |-> !$past(i_cs_b, 3))
        else $error("access without chip select");
    a_ack_at_wr: assert property (o_reg_wr |-> $past(!o_cycle_done_ack)
        ##[1:3] o_cycle_done_ack)
        else $error("done ack wrong around write");
    a_rst_idle: assert property (!o_rst_sys_b |-> o_cycle_done_ack && !o_data_oe)
        else $error("outputs not idle in reset");
    a_rd_release: assert property ($fell(o_data_oe) |-> ##[0:3] o_cycle_done_ack)
        else $error("ack not released after read");
endmodule
bind dhp_host_port dhp_host_port_asserts u_chk (.i_clk_sys, .i_rst_b, .i_cs_b, .o_data,
    .o_data_oe, .o_cycle_done_ack, .o_int_oe, .o_int_b, .i_int_pending, .o_rst_sys_b,
    .o_reg_wr, .o_reg_rd, .i_reg_rdata);

// ### verif/dhp_host_model.sv
// Purpose: Host processor model for both bus styles.
// Assumes: Strap value given on i_style.
// Notes: Address bus shows the inverse once latched.
`timescale 1ns/1ns
module dhp_host_model
import dhp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_style,
    input wire logic i_ack_b,
    input wire dhp_data_t i_bus,
    output logic o_cs_b,
    output dhp_addr_t o_addr,
    output dhp_data_t o_data,
    output logic o_data_oe,
    output logic o_als,
    output logic o_rds,
    output logic o_wod
);
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic idle();
        o_cs_b <= 1'b1;
        o_als <= i_style;
        o_rds <= 1'b1;
        o_wod <= 1'b1;
        o_data_oe <= 1'b0;
    endtask
    task automatic wait_ack(input logic lvl, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge i_clk_sys);
            ok = (i_ack_b === lvl);
        end
    endtask
    task automatic access(input logic wr, input logic sel, input dhp_addr_t a,
                          input dhp_data_t d, output dhp_data_t q, output logic ok);
        logic k;
        @(posedge i_clk_sys);
        o_cs_b <= ~sel;
        o_addr <= a;
        o_als <= ~i_style;
        o_wod <= i_style ? ~wr : 1'b1;
        cyc(4);
        o_als <= i_style;
        cyc(1);
        o_addr <= ~a;
        cyc(4);
        o_data <= d;
        o_data_oe <= wr;
        if (i_style || !wr) o_rds <= 1'b0;
        else o_wod <= 1'b0;
        wait_ack(1'b0, ok);
        q = i_bus;
        o_rds <= 1'b1;
        if (!i_style) o_wod <= 1'b1;
        wait_ack(1'b1, k);
        idle();
        cyc(2);
    endtask
endmodule

// ### verif/test_dual_style_host_bus_port.sv
// Purpose: Self-checking bench for the host port.
// Assumes: Register store modelled here.
// Notes: Undriven data bus shows the inverse of its last value.
`timescale 1ns/1ns
module test_dual_style_host_bus_port;
import dhp_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic style = 1'b0;
    logic int_pend = 1'b0;
    logic cs_b, als, rds, wod, hoe, ack_b, int_oe, int_b, oe, sys_rst_b, reg_wr, reg_rd;
    dhp_addr_t addr, reg_addr;
    dhp_data_t hdata, dout, bus, reg_wdata, rdata;
    dhp_data_t last_ff = 8'h00;
    dhp_data_t mem [512];
    int n_mismatch = 0;
    int n_compared = 0;
    assign bus = oe ? dout : (hoe ? hdata : ~last_ff);
    assign rdata = mem[reg_addr];
    always @(posedge clk) begin
        last_ff <= bus;
        if (reg_wr) mem[reg_addr] <= reg_wdata;
    end
    dhp_host_port DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_bus_style_select(style),
        .i_cs_b(cs_b), .i_addr(addr), .i_data(bus), .o_data(dout), .o_data_oe(oe),
        .i_address_latch_strobe(als), .i_read_or_data_strobe(rds), .i_write_or_dir(wod),
        .o_cycle_done_ack(ack_b), .o_int_oe(int_oe), .o_int_b(int_b),
        .i_int_pending(int_pend), .o_rst_sys_b(sys_rst_b), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .i_reg_rdata(rdata));
    dhp_host_model host (.i_clk_sys(clk), .i_style(style), .i_ack_b(ack_b), .i_bus(bus),
        .o_cs_b(cs_b), .o_addr(addr), .o_data(hdata), .o_data_oe(hoe), .o_als(als),
        .o_rds(rds), .o_wod(wod));
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_b <= 1'b0;
        style <= s;
        @(posedge clk);
        host.idle();
        repeat (2) @(posedge clk);
        check("ack in reset", ack_b, 1'b1);
        check("oe in reset", oe, 1'b0);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // Write then read back a table; boundary addresses included
    task automatic t_rw(input logic s, input dhp_addr_t a [3], input dhp_data_t d [3]);
        dhp_data_t q;
        logic ok;
        do_reset(s);
        for (int i = 0; i < 3; i++) begin
            host.access(1'b1, 1'b1, a[i], d[i], q, ok);
            check("write done", ok, 1'b1);
            check("stored", mem[a[i]], d[i]);
        end
        for (int i = 0; i < 3; i++) begin
            host.access(1'b0, 1'b1, a[i], 8'h00, q, ok);
            check("read data", q, d[i]);
            check("bus released", oe, 1'b0);
        end
    endtask
    task automatic t_cs();
        dhp_data_t q;
        logic ok;
        host.access(1'b1, 1'b0, 9'h0A5, 8'h18, q, ok);
        check("deselected wr ack", ok, 1'b0);
        check("deselected wr", mem[9'h0A5], 8'h81);
        host.access(1'b0, 1'b0, 9'h0A5, 8'h00, q, ok);
        check("deselected rd ack", ok, 1'b0);
        check("deselected oe", oe, 1'b0);
    endtask
    task automatic t_int();
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            int_pend <= i[0];
            @(posedge clk);
            #1;
            check("int enable", int_oe, i[0]);
            check("int level", int_b, 1'b0);
        end
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        t_rw(1'b0, '{9'h000, 9'h1FF, 9'h0A5}, '{8'h5A, 8'hC3, 8'h81});
        t_cs();
        t_int();
        t_rw(1'b1, '{9'h1FF, 9'h001, 9'h100}, '{8'h3C, 8'hE7, 8'h96});
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
